/* rtl/split_timer_pkg.sv */
package split_timer_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_VALUE_LOW = 8'h92;

  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_EXT_CLK    = 0;

  // Writable bits; bits 4 and 1 read zero
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hed;
  localparam logic [7:0] RESET_VALUE        = 8'h00;

  // ****************************************
  // Tick dividers
  // ****************************************
  localparam int         SYS_DIV        = 12;
  localparam int         EXT_DIV        = 8;
  localparam logic [3:0] SYS_DIV_LAST   = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST   = 3'(EXT_DIV - 1);

  // Register write strobe
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

/* rtl/split_autoreload_timer_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - High overflow flag sets when upper count byte rolls from 0xFF and is reloaded.
// - In 16-bit mode high flag sets on full wrap from 0xFFFF to the 16-bit reload value.
// - Set high flag requests timer interrupt when timer interrupt is enabled.
// - Hardware never clears overflow flags; software clears them by writing zero.
// - Low overflow flag bit 6 sets on each lower byte roll, any mode.
// - Low irq enable bit 5 plus timer enable raises interrupt per low overflow.
// - Split select bit 3: 0 one 16-bit counter, 1 two 8-bit counters.
// - In 16-bit mode counter advances only while run control bit 2 is one.
// - In split mode run gates upper half only; lower always counts.
// - Control bits 4 and 1 read zero and ignore writes.
// - External clock select 0 uses system clock divided by 12.
// - External clock select 1 uses synchronized external oscillator divided by 8.
// - Per-half fast clock selects override external select independently in split mode; 16-bit mode uses only the lower select.
// - Reload low byte at 0x92 is read/write storage for reload bits 7:0.
// - 16-bit wrap from 0xFFFF loads the 16-bit reload value.
// - In split mode each half reloads from its own reload byte.
// - Half with fast clock select set counts on every system clock; in 16-bit mode the upper select is ignored.
module split_autoreload_timer_ctrl (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire split_timer_pkg::reg_write_t reg_write,
  input  wire logic [7:0]                 reg_read_addr,
  output logic [7:0]                      reg_read_data,
  input  wire logic                       ext_osc_div8_tick,
  input  wire logic                       upper_half_fast_clock_select,
  input  wire logic                       lower_half_fast_clock_select,
  input  wire logic [7:0]                 reload_value_high,
  input  wire logic                       count_write_lower,
  input  wire logic                       count_write_upper,
  input  wire logic [7:0]                 count_write_data,
  input  wire logic                       timer_irq_enable,
  output logic [7:0]                      count_lower_byte,
  output logic [7:0]                      count_upper_byte,
  output logic                            timer_irq
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] timer_control;
  logic [7:0] reload_value_low;
  logic [7:0] next_timer_control;
  logic [7:0] next_reload_value_low;
  logic [3:0] sys_div;
  logic [3:0] next_sys_div;
  logic [7:0] next_count_lower_byte;
  logic [7:0] next_count_upper_byte;

  logic sys_tick;
  logic slow_tick;
  logic lower_tick;
  logic upper_tick;
  logic lower_roll;
  logic upper_roll;
  logic split;
  logic run;
  logic ctrl_wr;

  assign split   = timer_control[split_timer_pkg::BIT_SPLIT];
  assign run     = timer_control[split_timer_pkg::BIT_RUN];
  assign ctrl_wr = reg_write.wr && (reg_write.addr == split_timer_pkg::ADDR_TIMER_CONTROL);

  // ****************************************
  // Tick generation
  // ****************************************
  always_comb begin
    next_sys_div = (sys_div == split_timer_pkg::SYS_DIV_LAST) ? 4'h0 : sys_div + 4'h1;
  end

  assign sys_tick = (sys_div == split_timer_pkg::SYS_DIV_LAST);

  assign slow_tick = timer_control[split_timer_pkg::BIT_EXT_CLK] ? ext_osc_div8_tick : sys_tick;

  // per-half override, fast clock, one-cycle ticks
  always_comb begin
    lower_tick = lower_half_fast_clock_select ? 1'b1 : slow_tick;
    upper_tick = upper_half_fast_clock_select ? 1'b1 : slow_tick;
    // mode selects clocking of upper half
    if (!split) begin
      lower_tick = lower_tick && run;
      upper_tick = 1'b0;
    end else begin
      upper_tick = upper_tick && run;
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  always_comb begin
    lower_roll = lower_tick && (count_lower_byte == 8'hff);
    upper_roll = split ? (upper_tick && (count_upper_byte == 8'hff))
                       : (lower_roll && (count_upper_byte == 8'hff));
    next_count_lower_byte = count_lower_byte;
    next_count_upper_byte = count_upper_byte;
    if (!split) begin
      if (upper_roll) begin
        next_count_lower_byte = reload_value_low;
        next_count_upper_byte = reload_value_high;
      end else if (lower_tick) begin
        next_count_lower_byte = count_lower_byte + 8'h01;
        if (lower_roll) begin
          next_count_upper_byte = count_upper_byte + 8'h01;
        end
      end
    end else begin
      if (lower_tick) begin
        next_count_lower_byte = lower_roll ? reload_value_low : count_lower_byte + 8'h01;
      end
      if (upper_tick) begin
        next_count_upper_byte = upper_roll ? reload_value_high : count_upper_byte + 8'h01;
      end
    end
    if (count_write_lower) begin
      next_count_lower_byte = count_write_data;
    end
    if (count_write_upper) begin
      next_count_upper_byte = count_write_data;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    next_timer_control    = timer_control;
    next_reload_value_low = reload_value_low;
    if (ctrl_wr) begin
      next_timer_control = reg_write.data & split_timer_pkg::CONTROL_WRITE_MASK;
    end
    if (reg_write.wr && (reg_write.addr == split_timer_pkg::ADDR_RELOAD_VALUE_LOW)) begin
      next_reload_value_low = reg_write.data;
    end
    // upper roll sets high flag; set wins over clear
    if (upper_roll) begin
      next_timer_control[split_timer_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
    if (lower_roll) begin
      next_timer_control[split_timer_pkg::BIT_LOW_FLAG] = 1'b1;
    end
  end

  always_comb begin
    case (reg_read_addr)
      split_timer_pkg::ADDR_TIMER_CONTROL:    reg_read_data = timer_control;
      split_timer_pkg::ADDR_RELOAD_VALUE_LOW: reg_read_data = reload_value_low;
      default:                                reg_read_data = 8'h00;
    endcase
  end

  // high flag request, low flag request when enabled
  assign timer_irq = timer_irq_enable && (timer_control[split_timer_pkg::BIT_HIGH_FLAG] ||
                     (timer_control[split_timer_pkg::BIT_LOW_FLAG] &&
                      timer_control[split_timer_pkg::BIT_LOW_IRQ_EN]));

  // ****************************************
  // State registers
  // ****************************************
  // Divider free-runs from reset, so the first slow tick may come early
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sys_div <= 4'h0;
    end else begin
      sys_div <= next_sys_div;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_lower_byte <= split_timer_pkg::RESET_VALUE;
      count_upper_byte <= split_timer_pkg::RESET_VALUE;
    end else begin
      count_lower_byte <= next_count_lower_byte;
      count_upper_byte <= next_count_upper_byte;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_control    <= split_timer_pkg::RESET_VALUE;
      reload_value_low <= split_timer_pkg::RESET_VALUE;
    end else begin
      timer_control    <= next_timer_control;
      reload_value_low <= next_reload_value_low;
    end
  end

endmodule

/* dv/split_timer_checker.sv */
`timescale 1ns/1ps
module split_timer_checker (
  input wire logic       sys_clk, rst, count_write_lower, count_write_upper, timer_irq_enable, timer_irq,
  input wire logic       upper_half_fast_clock_select, lower_half_fast_clock_select,
  input wire logic [7:0] reg_read_addr, reg_read_data, reload_value_high, count_lower_byte, count_upper_byte,
  input wire split_timer_pkg::reg_write_t reg_write
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Control is only visible while the bench reads it
  wire       ctl   = reg_read_addr == 8'h91;
  wire       quiet = !reg_write.wr && !count_write_lower && !count_write_upper;
  wire [7:0] d     = reg_read_data;
  a_unused_bits: assert property (ctl |-> !d[4] && !d[1]) else $error("unused control bit reads one");
  a_unmapped_zero: assert property (!ctl && reg_read_addr != 8'h92 |-> d == 8'h00) else $error("unmapped read");
  a_irq_source: assert property (ctl |-> timer_irq == (timer_irq_enable && (d[7] || d[6] && d[5])))
    else $error("interrupt does not follow flags");
  a_flags_sticky: assert property (ctl && quiet ##1 ctl |-> (d[7:6] & $past(d[7:6])) == $past(d[7:6]))
    else $error("overflow flag cleared by hardware");
  a_reload_low_rw: assert property (reg_write.wr && reg_write.addr == 8'h92 ##1 reg_read_addr == 8'h92
    |-> d == $past(reg_write.data)) else $error("reload low byte not stored");
  a_stop_16bit: assert property (ctl && !d[3] && !d[2] && quiet |=> $stable({count_upper_byte, count_lower_byte}))
    else $error("counter moved while stopped");
  a_split_upper_hold: assert property (ctl && d[3] && !d[2] && quiet |=> $stable(count_upper_byte))
    else $error("upper half moved while stopped");
  a_upper_fast_step: assert property (ctl && d[3] && d[2] && upper_half_fast_clock_select && quiet |=>
    count_upper_byte == ($past(count_upper_byte) == 8'hff ? $past(reload_value_high) : $past(count_upper_byte) + 8'h01))
    else $error("upper half fast count wrong");
  a_low_wrap_flag: assert property (ctl && (d[3] || d[2]) && lower_half_fast_clock_select && quiet
    && count_lower_byte == 8'hff |=> !ctl || d[6]) else $error("low overflow flag not set");
endmodule

/* dv/split_autoreload_timer_ctrl_bench.sv */
`timescale 1ns/1ps
module split_autoreload_timer_ctrl_bench;
  logic sys_clk = 1'b0, rst = 1'b1, ext_osc_div8_tick = 1'b0, count_write_lower = 1'b0, count_write_upper = 1'b0;
  logic upper_half_fast_clock_select = 1'b1, lower_half_fast_clock_select = 1'b1, timer_irq_enable = 1'b1, timer_irq;
  logic [7:0] reg_read_addr = 8'h91, reload_value_high = 8'h12, count_write_data = 8'h00, reg_read_data;
  logic [7:0] count_lower_byte, count_upper_byte;
  split_timer_pkg::reg_write_t reg_write = '0;
  int num_errors = 0, num_checks = 0, cycles = 0;
  split_autoreload_timer_ctrl u_dut (.sys_clk, .rst, .reg_write, .reg_read_addr, .reg_read_data, .ext_osc_div8_tick,
    .upper_half_fast_clock_select, .lower_half_fast_clock_select, .reload_value_high, .count_write_lower,
    .count_write_upper, .count_write_data, .timer_irq_enable, .count_lower_byte, .count_upper_byte, .timer_irq);
  always #4 sys_clk = ~sys_clk;
  // Free-running external tick, so any 24 edges hold exactly 3
  always @(negedge sys_clk) ext_osc_div8_tick <= cycles % 8 == 0;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) summarize(1'b1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cr(input logic [7:0] a, input logic [7:0] exp);
    reg_read_addr = a;
    #1 chk({8'h00, reg_read_data}, {8'h00, exp});
    @(negedge sys_clk);
  endtask
  // Address 0x94 loads both count bytes; the block must ignore it as a register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_write = '{1'b1, a, v};
    {count_write_lower, count_write_upper, count_write_data} = {{2{a == 8'h94}}, v};
    @(negedge sys_clk);
    {reg_write.wr, count_write_lower, count_write_upper} = 3'b000;
    // Idle cycle so back-to-back calls never re-raise the strobe in one step
    @(negedge sys_clk);
  endtask
  task automatic summarize(input logic hung);
    num_errors += hung;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_regs;
    cr(8'h92, 8'h00);
    wr(8'h92, 8'h34);
    cr(8'h92, 8'h34);
    wr(8'h91, 8'hff);
    cr(8'h91, 8'hed);
  endtask
  task automatic t_wrap16;
    wr(8'h91, 8'h00);
    wr(8'h94, 8'hff);
    wr(8'h91, 8'h04);
    chk({count_upper_byte, count_lower_byte}, 16'h1234);
    cr(8'h91, 8'hc4);
    chk({15'h0000, timer_irq}, 16'h0001);
    wr(8'h91, 8'h00);
    cr(8'h91, 8'h00);
    chk({15'h0000, timer_irq}, 16'h0000);
  endtask
  task automatic t_sources;
    lower_half_fast_clock_select = 1'b0;
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h04);
    repeat (59) @(negedge sys_clk);
    chk({count_upper_byte, count_lower_byte}, 16'h0005);
    wr(8'h91, 8'h05);
    wr(8'h94, 8'h00);
    repeat (23) @(negedge sys_clk);
    chk({count_upper_byte, count_lower_byte}, 16'h0003);
  endtask
  task automatic t_split;
    lower_half_fast_clock_select = 1'b1;
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h40);
    wr(8'h94, 8'hff);
    wr(8'h91, 8'h2d);
    chk({count_upper_byte, count_lower_byte}, 16'h1240);
    cr(8'h91, 8'hed);
    wr(8'h91, 8'h68);
    repeat (2) @(negedge sys_clk);
    chk({count_upper_byte, count_lower_byte}, 16'h1445);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_regs();
    t_wrap16();
    t_sources();
    t_split();
    summarize(1'b0);
  end
endmodule
bind split_autoreload_timer_ctrl split_timer_checker u_chk (.sys_clk, .rst, .reg_write, .reg_read_addr, .reg_read_data,
  .upper_half_fast_clock_select, .lower_half_fast_clock_select, .reload_value_high, .count_write_lower,
  .count_write_upper, .timer_irq_enable, .count_lower_byte, .count_upper_byte, .timer_irq);
